// ### verilog/asp_top.sv
// Purpose: Sync/power-down sequencing, toy decimation filter and daisy-chain serial readout.
// Assumes: sample_in comes from logic on mclk; pins sync, cs and the chain input are external.
// Notes: The serial side runs on sclk; the output word is held still while data-ready is low.
//
// Contract
// - Sync low sampled on an mclk rise enters power-down.
// - Entering power-down drives data-ready high, marking the output word invalid.
// - In power-down the sync input is examined on every mclk rise.
// - First mclk rise after sync returns high leaves power-down; the code leaves on the third rise, after the two sync flops.
// - Next mclk rise after leaving power-down clears the decimation filter.
// - Following mclk rise takes the first new sample.
// - Data-ready stays high until settling ends, then falls with a valid word.
// - Settling is 594, 1186 or 2370 mclk periods plus fixed delay.
// - Result is 24-bit two's complement, MSB first.
// - Serial output not driven while chip select is high.
// - MSB shows at chip-select fall or data-ready fall; later sclk falls shift.
// - Device acts as a shift register on sclk falling edges for the chain.
// - Chain delivers nearest device's word first, then farther ones, MSB first.
module asp_top #(
    parameter int DECIMATION = asp_pkg::DEC_BY_8,
    parameter int SETTLE_EXTRA = 2
) (
    // Master clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Control pins.
    input wire logic sync_powerdown_n,
    output logic data_ready_n,
    // Converter core interface.
    input wire logic [asp_pkg::RESULT_W-1:0] sample_in,
    output logic sample_take,
    output logic filter_reset,
    output logic powered_down,
    // Serial interface, clocked by the host.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe_n
);

    localparam int LOG_DEC = $clog2(DECIMATION);
    localparam int ACC_W = asp_pkg::RESULT_W + LOG_DEC;
    localparam int SETTLE_CYC = asp_pkg::asp_settle(DECIMATION) + SETTLE_EXTRA;
    localparam logic [asp_pkg::CNT_W-1:0] SETTLE_LOAD = asp_pkg::CNT_W'(SETTLE_CYC - 1);
    localparam logic [asp_pkg::CNT_W-1:0] PERIOD_LOAD = asp_pkg::CNT_W'(DECIMATION - 1);
    localparam logic [LOG_DEC-1:0] DEC_LAST = LOG_DEC'(DECIMATION - 1);

    logic rst_meta_ff;
    logic rst_sync_n_ff;
    logic sync_meta_ff;
    logic sync_ff;
    asp_pkg::asp_state_t state_ff;
    asp_pkg::asp_state_t nxt_state;
    logic [asp_pkg::CNT_W-1:0] cnt_ff;
    logic [asp_pkg::CNT_W-1:0] nxt_cnt;
    logic data_ready_n_ff;
    logic nxt_data_ready_n;
    logic [asp_pkg::RESULT_W-1:0] word_ff;
    logic [asp_pkg::RESULT_W-1:0] nxt_word;
    logic signed [ACC_W-1:0] acc_ff;
    logic signed [ACC_W-1:0] nxt_acc;
    logic signed [ACC_W-1:0] acc_sum;
    logic [LOG_DEC-1:0] dec_cnt_ff;
    logic [LOG_DEC-1:0] nxt_dec_cnt;
    logic [asp_pkg::RESULT_W-1:0] filt_ff;
    logic [asp_pkg::RESULT_W-1:0] nxt_filt;
    logic frame_clear;
    logic serial_bit;

    // Reset is asserted at once and released through two flops.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_n_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_n_ff <= rst_meta_ff;
        end
    end

    // The sync pin is asynchronous to mclk, so it passes two flops first.
    always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            sync_meta_ff <= 1'b1;
            sync_ff <= 1'b1;
        end else begin
            sync_meta_ff <= sync_powerdown_n;
            sync_ff <= sync_meta_ff;
        end
    end

    // Sequencer: power-down, exit, filter reset, settling and periodic result updates.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_data_ready_n = data_ready_n_ff;
        nxt_word = word_ff;
        if (!sync_ff) begin
            nxt_state = asp_pkg::ASP_PD;
            nxt_data_ready_n = 1'b1;
        end else begin
            case (state_ff)
                asp_pkg::ASP_PD: begin
                    nxt_state = asp_pkg::ASP_EXIT;
                    nxt_cnt = SETTLE_LOAD;
                end
                asp_pkg::ASP_EXIT: begin
                    nxt_state = asp_pkg::ASP_FRST;
                    nxt_cnt = cnt_ff - 1'b1;
                end
                asp_pkg::ASP_FRST: begin
                    nxt_state = asp_pkg::ASP_SETTLE;
                    nxt_cnt = cnt_ff - 1'b1;
                end
                asp_pkg::ASP_SETTLE: begin
                    if (cnt_ff == '0) begin
                        nxt_state = asp_pkg::ASP_READY;
                        nxt_data_ready_n = 1'b0;
                        nxt_word = filt_ff;
                        nxt_cnt = PERIOD_LOAD;
                    end else begin
                        nxt_cnt = cnt_ff - 1'b1;
                    end
                end
                asp_pkg::ASP_READY: begin
                    // One high cycle while the word changes keeps readers off a moving word.
                    nxt_data_ready_n = 1'b0;
                    if (cnt_ff == '0) begin
                        nxt_data_ready_n = 1'b1;
                        nxt_word = filt_ff;
                        nxt_cnt = PERIOD_LOAD;
                    end else begin
                        nxt_cnt = cnt_ff - 1'b1;
                    end
                end
                default: begin
                    nxt_state = asp_pkg::ASP_PD;
                    nxt_data_ready_n = 1'b1;
                end
            endcase
        end
    end

    // Sequencer registers.
    always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            state_ff <= asp_pkg::ASP_PD;
            cnt_ff <= '0;
            data_ready_n_ff <= asp_pkg::DATA_READY_N_RESET;
            word_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            data_ready_n_ff <= nxt_data_ready_n;
            word_ff <= nxt_word;
        end
    end

    // Block-average filter standing in for the decimator; cleared on the filter reset edge.
    assign acc_sum = acc_ff + ACC_W'(signed'(sample_in));
    always_comb begin
        nxt_acc = acc_ff;
        nxt_dec_cnt = dec_cnt_ff;
        nxt_filt = filt_ff;
        if (state_ff == asp_pkg::ASP_EXIT) begin
            nxt_acc = '0;
            nxt_dec_cnt = '0;
        end else if (sample_take) begin
            if (dec_cnt_ff == DEC_LAST) begin
                nxt_filt = asp_pkg::RESULT_W'(acc_sum >>> LOG_DEC);
                nxt_acc = '0;
                nxt_dec_cnt = '0;
            end else begin
                nxt_acc = acc_sum;
                nxt_dec_cnt = dec_cnt_ff + 1'b1;
            end
        end
    end

    // Filter registers.
    always_ff @(posedge mclk or negedge rst_sync_n_ff) begin
        if (!rst_sync_n_ff) begin
            acc_ff <= '0;
            dec_cnt_ff <= '0;
            filt_ff <= '0;
        end else begin
            acc_ff <= nxt_acc;
            dec_cnt_ff <= nxt_dec_cnt;
            filt_ff <= nxt_filt;
        end
    end

    // Samples are taken from the edge after the filter reset onward.
    assign sample_take = (state_ff == asp_pkg::ASP_FRST) || (state_ff == asp_pkg::ASP_SETTLE) ||
                         (state_ff == asp_pkg::ASP_READY);
    assign filter_reset = (state_ff == asp_pkg::ASP_EXIT);
    assign powered_down = (state_ff == asp_pkg::ASP_PD);
    assign data_ready_n = data_ready_n_ff;

    // A frame opens at data-ready fall or chip-select fall; both are levels from flops or pins.
    assign frame_clear = data_ready_n_ff | cs_n;

    // Serial clock side; the word it reads is held still for the whole open frame.
    asp_shift #(
        .WIDTH(asp_pkg::RESULT_W)
    ) u_shift (
        .sclk(sclk),
        .rst_n(rst_n),
        .frame_clear(frame_clear),
        .word(word_ff),
        .serial_data_in(serial_data_in),
        .serial_bit(serial_bit)
    );

    // Chip select gates the line so several devices may share it.
    assign serial_data_out = serial_bit;
    assign serial_data_out_oe_n = cs_n;

endmodule : asp_top

// ### verilog/asp_pkg.sv
// Purpose: Shared constants for the sync, power-down and daisy-chain readout block.
// Assumes: The converter core delivers one 24-bit two's-complement sample per master clock.
// Notes: Settling counts are in master-clock periods and exclude the fixed extra delay.
package asp_pkg;

    // Width of one conversion result on the serial output.
    localparam int RESULT_W = 24;
    // Width of the shift position counter in the serial clock domain.
    localparam int POS_W = 5;

    // Supported decimation ratios.
    localparam int DEC_BY_8 = 8;
    localparam int DEC_BY_16 = 16;
    localparam int DEC_BY_32 = 32;

    // Filter settling in master-clock periods for each decimation ratio.
    localparam int SETTLE_DEC8 = 594;
    localparam int SETTLE_DEC16 = 1186;
    localparam int SETTLE_DEC32 = 2370;

    // Width of the settling and conversion-period counter.
    localparam int CNT_W = 12;

    // Reset value of the data-ready output: high marks the output word invalid.
    localparam logic DATA_READY_N_RESET = 1'b1;

    // Control sequence after the sync input is released.
    typedef enum logic [2:0] {
        ASP_PD = 3'h0,
        ASP_EXIT = 3'h1,
        ASP_FRST = 3'h2,
        ASP_SETTLE = 3'h3,
        ASP_READY = 3'h4
    } asp_state_t;

    // Settling count for a decimation ratio; unknown ratios fall back to the shortest.
    function automatic int asp_settle(input int dec);
        int res;
        res = SETTLE_DEC8;
        if (dec == DEC_BY_16) begin
            res = SETTLE_DEC16;
        end else if (dec == DEC_BY_32) begin
            res = SETTLE_DEC32;
        end
        return res;
    endfunction : asp_settle

endpackage : asp_pkg

// ### verilog/asp_shift.sv
// Purpose: Serial output shift register clocked by the host serial clock.
// Assumes: The parallel word is stable whenever frame_clear is low.
// Notes: frame_clear clears the position asynchronously, so the MSB shows before any clock edge.
module asp_shift #(
    parameter int WIDTH = asp_pkg::RESULT_W
) (
    // Serial clock domain.
    input wire logic sclk,
    input wire logic rst_n,
    input wire logic frame_clear,
    // Data.
    input wire logic [WIDTH-1:0] word,
    input wire logic serial_data_in,
    output logic serial_bit
);

    logic [WIDTH-1:0] sreg_ff;
    logic [WIDTH-1:0] nxt_sreg;
    logic [asp_pkg::POS_W-1:0] pos_ff;
    logic [asp_pkg::POS_W-1:0] nxt_pos;

    // First falling edge takes the held word; every edge also pulls in the chain input.
    always_comb begin
        nxt_pos = pos_ff;
        if (pos_ff == '0) begin
            nxt_sreg = {word[WIDTH-2:0], serial_data_in};
        end else begin
            nxt_sreg = {sreg_ff[WIDTH-2:0], serial_data_in};
        end
        if (pos_ff != asp_pkg::POS_W'(WIDTH)) begin
            nxt_pos = pos_ff + 1'b1;
        end
    end

    // Falling edges shift; a stopped serial clock between frames is harmless here.
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            sreg_ff <= '0;
        end else begin
            sreg_ff <= nxt_sreg;
        end
    end

    // Position is cleared while no frame is open, by a constant only.
    always_ff @(negedge sclk or posedge frame_clear or negedge rst_n) begin
        if (!rst_n) begin
            pos_ff <= '0;
        end else if (frame_clear) begin
            pos_ff <= '0;
        end else begin
            pos_ff <= nxt_pos;
        end
    end

    // After the own bits, the register carries chain input bits in arrival order.
    assign serial_bit = (pos_ff == '0) ? word[WIDTH-1] : sreg_ff[WIDTH-1];

endmodule : asp_shift

// ### tb/asp_top_monitor.sv
// Purpose: Concurrent checks of sync sequencing, settling and serial enable.
// Assumes: SETTLE_CYC is the settling count of the bound instance.
// Notes: Settling is timed by a counter that the filter reset starts.
module asp_top_monitor #(
    parameter int SETTLE_CYC = 596
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Watched pins.
    input wire logic sync_powerdown_n,
    input wire logic data_ready_n,
    input wire logic filter_reset,
    input wire logic sample_take,
    input wire logic powered_down,
    input wire logic cs_n,
    input wire logic serial_data_out_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [11:0] cnt_ff;
    logic [11:0] nxt_cnt;
    // Cleared in power-down, so an aborted sequence reaches the end count at most in its first power-down cycle.
    always_comb begin
        nxt_cnt = (cnt_ff != 12'h000 && cnt_ff != 12'hFFF) ? cnt_ff + 12'h001 : cnt_ff;
        if (filter_reset) nxt_cnt = 12'h001;
        if (powered_down) nxt_cnt = 12'h000;
    end
    // Counter register.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) cnt_ff <= 12'h000;
        else cnt_ff <= nxt_cnt;
    end
    property p_enter_pd; $fell(sync_powerdown_n) |-> ##[1:4] powered_down; endproperty
    a_enter_pd: assert property (p_enter_pd) else $error("no power-down after sync low");
    property p_pd_data_ready_n; powered_down |-> data_ready_n; endproperty
    a_pd_data_ready_n: assert property (p_pd_data_ready_n) else $error("ready low in power-down");
    property p_leave_pd; sync_powerdown_n [*8] |-> !powered_down; endproperty
    a_leave_pd: assert property (p_leave_pd) else $error("power-down held with sync high");
    property p_exit_frst; $fell(powered_down) |-> filter_reset; endproperty
    a_exit_frst: assert property (p_exit_frst) else $error("no filter reset on exit");
    // A sync pulse that lands on the exit cycle legally aborts, so only an undisturbed exit is checked.
    property p_first_sample; filter_reset && $past(sync_powerdown_n, 2) |=> sample_take && !filter_reset; endproperty
    a_first_sample: assert property (p_first_sample) else $error("no sample after filter reset");
    property p_settle_high; cnt_ff != 12'h000 && cnt_ff < 12'(SETTLE_CYC) |-> data_ready_n; endproperty
    a_settle_high: assert property (p_settle_high) else $error("ready low while settling");
    property p_settle_end; cnt_ff == 12'(SETTLE_CYC) && !powered_down |-> $fell(data_ready_n); endproperty
    a_settle_end: assert property (p_settle_end) else $error("ready fall off settling count");
    property p_oe; serial_data_out_oe_n == cs_n; endproperty
    a_oe: assert property (p_oe) else $error("output enable differs from select");
    c_settled: cover property (cnt_ff == 12'(SETTLE_CYC));
    c_abort: cover property (cnt_ff != 12'h000 ##1 powered_down);
    c_frame: cover property (!cs_n && !data_ready_n);
endmodule : asp_top_monitor

bind asp_top asp_top_monitor #(.SETTLE_CYC(asp_pkg::SETTLE_DEC8 + SETTLE_EXTRA)) u_mon (.mclk(mclk), .rst_n(rst_n),
    .sync_powerdown_n(sync_powerdown_n), .data_ready_n(data_ready_n), .filter_reset(filter_reset),
    .sample_take(sample_take), .powered_down(powered_down), .cs_n(cs_n),
    .serial_data_out_oe_n(serial_data_out_oe_n));

// ### tb/asp_host_model.sv
// Purpose: Host that reads the chain, with the far chained device folded in.
// Assumes: The far device shares sclk and chip select and feeds serial_data_in.
// Notes: The serial clock idles high and toggles at 32 ns only inside frames.
module asp_host_model (
    // Host-driven lines; sclk and cs_n are common to every chained device, serial_data_in is the far device's output.
    output logic sclk,
    output logic cs_n,
    output logic serial_data_in,
    // Device lines read back.
    input wire logic data_ready_n,
    input wire logic serial_data_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [23:0] far_word = 24'h000000;
    // Lines start idle.
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        serial_data_in = 1'b0;
    end
    // Two words in one ready-low window; 48 falls at 32 ns fit its 2540 ns.
    task automatic read_frame(input bit cs_first, output logic [47:0] got, output bit ok);
        int k;
        bit seen_high;
        got = 48'h000000000000;
        ok = 1'b0;
        // A gap after the previous frame keeps select from toggling twice in one time step.
        #16;
        if (cs_first) cs_n = 1'b0;
        for (k = 0; k < 20000 && data_ready_n !== 1'b1; k++) #5;
        seen_high = (data_ready_n === 1'b1);
        for (k = 0; seen_high && k < 20000 && data_ready_n !== 1'b0; k++) #5;
        if (seen_high && data_ready_n === 1'b0) begin
            cs_n = 1'b0;
            serial_data_in = far_word[23];
            // Exactly 24 falling edges per chained device, two devices here.
            for (k = 0; k < 48; k++) begin
                #8 got = {got[46:0], serial_data_out};
                #8 sclk = 1'b0;
                serial_data_in <= (k < 23) ? far_word[22 - k] : 1'b0;
                #16 sclk = 1'b1;
            end
            // Every bit must have left while ready is still low.
            ok = (data_ready_n === 1'b0);
            cs_n = 1'b1;
            serial_data_in = ~serial_data_in;
        end
    endtask : read_frame
endmodule : asp_host_model

// ### tb/asp_top_tb.sv
// Purpose: Self-checking bench for sync sequencing and daisy-chain readout.
// Assumes: A long decimation keeps the read window wide enough for two words.
// Notes: A constant sample makes each result equal to that sample.
module asp_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rst_n, sync_powerdown_n, sclk, cs_n, serial_data_in;
    logic data_ready_n, sample_take, filter_reset, powered_down, serial_data_out, serial_data_out_oe_n;
    logic [23:0] sample_in;
    logic [23:0] vals[3] = '{24'h000000, 24'h800000, 24'h7FFFFF};
    logic [47:0] exp_q[$];
    logic [47:0] got;
    bit ok;
    int miscompares = 0;
    int n_checks = 0;
    event got_ev;
    // Decimation of 128 gives a read window of 127 master cycles.
    asp_top #(.DECIMATION(128), .SETTLE_EXTRA(2)) dut (.mclk(mclk), .rst_n(rst_n),
        .sync_powerdown_n(sync_powerdown_n), .data_ready_n(data_ready_n), .sample_in(sample_in),
        .sample_take(sample_take), .filter_reset(filter_reset), .powered_down(powered_down), .sclk(sclk),
        .cs_n(cs_n), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_out_oe_n(serial_data_out_oe_n));
    asp_host_model host (.sclk(sclk), .cs_n(cs_n), .serial_data_in(serial_data_in),
        .data_ready_n(data_ready_n), .serial_data_out(serial_data_out));
    // Master clock.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic check(input logic [47:0] act, input logic [47:0] exp);
        n_checks++;
        if (act !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, act, exp);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    // Note the expected chain stream, then let the host read it.
    task automatic frame(input bit cs_first);
        exp_q.push_back({sample_in, host.far_word});
        host.read_frame(cs_first, got, ok);
        if (!ok) begin
            miscompares++;
            final_report();
        end else -> got_ev;
    endtask : frame
    task automatic sync_pulse(input int n);
        repeat (n) @(posedge mclk) sync_powerdown_n <= 1'b0;
        @(posedge mclk) sync_powerdown_n <= 1'b1;
    endtask : sync_pulse
    // Each finished frame is compared with the oldest note.
    always @(got_ev) begin
        check(got, exp_q.pop_front());
    end
    // Main sequence.
    initial begin
        void'($urandom(32'h576D1991));
        vals[0] = 24'($urandom);
        rst_n = 1'b0;
        sync_powerdown_n = 1'b1;
        sample_in = 24'h000000;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (20) @(posedge mclk);
        // Sign extremes and a random value, read after select and with select held low.
        foreach (vals[i]) begin
            host.far_word = 24'($urandom);
            @(posedge mclk) sample_in <= vals[i];
            sync_pulse(4);
            #1 check({47'h0, data_ready_n}, 48'h1);
            frame(1'b0);
            frame(1'b1);
        end
        // A second pulse mid-settling restarts the count, so ready stays high.
        sync_pulse(2);
        repeat (100) @(posedge mclk);
        sync_pulse(2);
        repeat (100) @(posedge mclk);
        #1 check({47'h0, data_ready_n}, 48'h1);
        frame(1'b0);
        // A reset in mid-run restarts the sequence with sync held high.
        @(posedge mclk) rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        frame(1'b0);
        // Let the compare process take the last frame before the verdict.
        @(posedge mclk);
        final_report();
    end
endmodule : asp_top_tb
